// file: cvt_pkg.sv
/*
 * Constants for the CRT/TV vertical timing and output control block:
 * register offsets, field positions, reset values and the line phase type.
 * Assumes an 8-bit register port with byte offsets and one 100 MHz clock.
 */
package cvt_pkg;

    // ------------------------------------------------------------
    // Port and field widths
    // ------------------------------------------------------------
    localparam int CVT_AW = 8;
    localparam int CVT_DW = 8;
    localparam int CVT_LINE_W = 10;
    localparam int CVT_HGT_HI_W = 2;
    localparam int CVT_VND_W = 7;
    localparam int CVT_VSS_W = 7;
    localparam int CVT_VSW_W = 3;
    localparam int CVT_IRQ_W = 3;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CVT_HGT_LO_ADDR = 8'h56;
    localparam logic [7:0] CVT_HGT_HI_ADDR = 8'h57;
    localparam logic [7:0] CVT_VND_ADDR = 8'h58;
    localparam logic [7:0] CVT_VSS_ADDR = 8'h59;
    localparam logic [7:0] CVT_VSW_ADDR = 8'h5a;
    localparam logic [7:0] CVT_TVC_ADDR = 8'h5b;
    localparam logic [7:0] CVT_IRQ_STAT_ADDR = 8'h5c;
    localparam logic [7:0] CVT_IRQ_MASK_ADDR = 8'h5d;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CVT_VND_STAT_BIT = 7;
    localparam int CVT_VSW_POL_BIT = 7;
    localparam int CVT_TVC_CHROMA_BIT = 5;
    localparam int CVT_TVC_LUMA_BIT = 4;
    localparam int CVT_TVC_DAC_BIT = 3;
    localparam int CVT_TVC_SVID_BIT = 1;
    localparam int CVT_TVC_PAL_BIT = 0;
    localparam int CVT_IRQ_BLANK_BIT = 0;
    localparam int CVT_IRQ_SYNC_BIT = 1;
    localparam int CVT_IRQ_FRAME_BIT = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CVT_REG_RST = 8'h00;
    localparam logic [9:0] CVT_LINE_RST = 10'h000;

    // Line phase of the frame
    typedef enum logic [0:0] {
        CVT_ACTIVE = 1'b0,
        CVT_BLANK = 1'b1
    } cvt_phase_t;

endpackage

// file: cvt_line_counter.sv
/*
 * Frame line counter: walks the active lines, then the vertical
 * non-display lines, then wraps. Assumes line_tick_i is a one-cycle
 * pulse per line from horizontal timing on the same clock.
 */
`timescale 1ns/1ps
module cvt_line_counter (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Line rate enable
    input wire logic line_tick_i,
    // Programmed lengths
    input wire logic [cvt_pkg::CVT_LINE_W-1:0] act_height_i,
    input wire logic [cvt_pkg::CVT_VND_W-1:0] vnd_period_i,
    // Position and events
    output logic in_blank_o,
    output logic [cvt_pkg::CVT_LINE_W-1:0] line_idx_o,
    output logic blank_start_o,
    output logic frame_start_o
);
    import cvt_pkg::*;

    cvt_phase_t phase;
    logic [CVT_LINE_W-1:0] vnd_ext;
    logic last_line;

    // ------------------------------------------------------------
    // Phase and line count
    // ------------------------------------------------------------
    assign vnd_ext = {3'h0, vnd_period_i};
    // Greater-or-equal so a shrunk length mid-frame still wraps
    assign last_line = (phase == CVT_ACTIVE) ? (line_idx_o >= act_height_i)
                                             : (line_idx_o >= vnd_ext);

    // Line counter and phase sequencing
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase <= CVT_ACTIVE;
            line_idx_o <= CVT_LINE_RST;
        end else if (line_tick_i) begin
            if (last_line) begin
                line_idx_o <= CVT_LINE_RST;
                case (phase)
                    CVT_ACTIVE: phase <= CVT_BLANK;
                    CVT_BLANK: phase <= CVT_ACTIVE;
                    default: phase <= CVT_ACTIVE;
                endcase
            end else begin
                line_idx_o <= line_idx_o + 10'h001;
            end
        end
    end

    // Phase flag and one-cycle phase events
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            in_blank_o <= 1'b0;
            blank_start_o <= 1'b0;
            frame_start_o <= 1'b0;
        end else begin
            in_blank_o <= (phase == CVT_BLANK);
            blank_start_o <= line_tick_i && last_line &&
                             (phase == CVT_ACTIVE);
            frame_start_o <= line_tick_i && last_line &&
                             (phase == CVT_BLANK);
        end
    end

endmodule

// file: cvt_vtiming.sv
/*
 * CRT/TV vertical timing and TV output control: register file, line
 * counter, vertical sync with polarity, blanking status and interrupt.
 * Assumes line_tick_i comes from horizontal timing on clock_i, and the
 * register master obeys the one-cycle strobe protocol.
 */
// Notes on behaviour
// - Active height is ten bits over two registers; lines equal value plus one.
// - Status bit 7 reads one during vertical non-display, zero when active.
// - Non-display period lasts the seven-bit field plus one lines.
// - Sync leading edge comes start field plus one lines into non-display.
// - Polarity bit one drives sync active high, zero drives it active low.
// - Sync stays active for width field plus one lines.
// - Control bit 5 enables the chrominance filter.
// - Control bit 4 enables the luminance filter.
// - Control bit 1 selects S-Video, zero selects composite.
// - Control bit 0 selects PAL, zero selects NTSC.
`timescale 1ns/1ps
module cvt_vtiming (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [cvt_pkg::CVT_AW-1:0] reg_addr_i,
    input wire logic [cvt_pkg::CVT_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [cvt_pkg::CVT_DW-1:0] reg_rdata_o,
    // Line rate enable from horizontal timing
    input wire logic line_tick_i,
    // Vertical timing outputs
    output logic vert_sync_o,
    output logic vblank_o,
    // TV output controls
    output logic chroma_filt_en_o,
    output logic luma_filt_en_o,
    output logic dac_level_sel_o,
    output logic svideo_sel_o,
    output logic pal_sel_o,
    // Interrupt
    output logic irq_o
);
    import cvt_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] hgt_lo;
    logic [CVT_HGT_HI_W-1:0] hgt_hi;
    logic [CVT_VND_W-1:0] vnd_period;
    logic [CVT_VSS_W-1:0] vsync_start;
    logic [CVT_VSW_W-1:0] vsync_width;
    logic vsync_pol;
    logic [CVT_IRQ_W-1:0] irq_stat;
    logic [CVT_IRQ_W-1:0] irq_mask;
    logic [CVT_IRQ_W-1:0] irq_evt;
    logic [CVT_LINE_W-1:0] act_height;
    logic [CVT_LINE_W-1:0] line_idx;
    logic [CVT_LINE_W-1:0] sync_first;
    logic [CVT_LINE_W-1:0] sync_end;
    logic in_blank;
    logic blank_start;
    logic frame_start;
    logic sync_act;
    logic next_sync_act;
    logic wr_hit_hgt_lo;
    logic wr_hit_hgt_hi;
    logic wr_hit_vnd;
    logic wr_hit_vss;
    logic wr_hit_vsw;
    logic wr_hit_tvc;
    logic [CVT_DW-1:0] next_rdata;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    assign wr_hit_hgt_lo = reg_wr_i && (reg_addr_i == CVT_HGT_LO_ADDR);
    assign wr_hit_hgt_hi = reg_wr_i && (reg_addr_i == CVT_HGT_HI_ADDR);
    assign wr_hit_vnd = reg_wr_i && (reg_addr_i == CVT_VND_ADDR);
    assign wr_hit_vss = reg_wr_i && (reg_addr_i == CVT_VSS_ADDR);
    assign wr_hit_vsw = reg_wr_i && (reg_addr_i == CVT_VSW_ADDR);
    assign wr_hit_tvc = reg_wr_i && (reg_addr_i == CVT_TVC_ADDR);

    // ------------------------------------------------------------
    // Timing registers
    // ------------------------------------------------------------
    // Height halves written separately; the counter sees each half as soon as it is written
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hgt_lo <= CVT_REG_RST;
            hgt_hi <= CVT_REG_RST[CVT_HGT_HI_W-1:0];
        end else begin
            if (wr_hit_hgt_lo) begin
                hgt_lo <= reg_wdata_i;
            end
            if (wr_hit_hgt_hi) begin
                hgt_hi <= reg_wdata_i[CVT_HGT_HI_W-1:0];
            end
        end
    end

    assign act_height = {hgt_hi, hgt_lo};

    // Non-display length; bit 7 is status and ignores writes
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vnd_period <= CVT_REG_RST[CVT_VND_W-1:0];
        end else if (wr_hit_vnd) begin
            vnd_period <= reg_wdata_i[CVT_VND_W-1:0];
        end
    end

    // Sync start, width and polarity
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vsync_start <= CVT_REG_RST[CVT_VSS_W-1:0];
            vsync_width <= CVT_REG_RST[CVT_VSW_W-1:0];
            vsync_pol <= 1'b0;
        end else begin
            if (wr_hit_vss) begin
                vsync_start <= reg_wdata_i[CVT_VSS_W-1:0];
            end
            if (wr_hit_vsw) begin
                vsync_width <= reg_wdata_i[CVT_VSW_W-1:0];
                vsync_pol <= reg_wdata_i[CVT_VSW_POL_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // TV output control register
    // ------------------------------------------------------------
    // The output pins are these flip-flops; no extra stage of delay
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chroma_filt_en_o <= 1'b0;
            luma_filt_en_o <= 1'b0;
            dac_level_sel_o <= 1'b0;
            svideo_sel_o <= 1'b0;
            pal_sel_o <= 1'b0;
        end else if (wr_hit_tvc) begin
            chroma_filt_en_o <= reg_wdata_i[CVT_TVC_CHROMA_BIT];
            luma_filt_en_o <= reg_wdata_i[CVT_TVC_LUMA_BIT];
            dac_level_sel_o <= reg_wdata_i[CVT_TVC_DAC_BIT];
            svideo_sel_o <= reg_wdata_i[CVT_TVC_SVID_BIT];
            pal_sel_o <= reg_wdata_i[CVT_TVC_PAL_BIT];
        end
    end

    // ------------------------------------------------------------
    // Line counter
    // ------------------------------------------------------------
    cvt_line_counter u_line_counter (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .line_tick_i(line_tick_i),
        .act_height_i(act_height),
        .vnd_period_i(vnd_period),
        .in_blank_o(in_blank),
        .line_idx_o(line_idx),
        .blank_start_o(blank_start),
        .frame_start_o(frame_start)
    );

    // ------------------------------------------------------------
    // Vertical sync
    // ------------------------------------------------------------
    // Window within non-display, counted from its first line as zero
    assign sync_first = {3'h0, vsync_start} + 10'h001;
    assign sync_end = sync_first + {7'h00, vsync_width} + 10'h001;
    // Sync is cut by frame start if software breaks the sum limit
    assign next_sync_act = in_blank && (line_idx >= sync_first) &&
                           (line_idx < sync_end);

    // Internal active-high sync and polarised pin
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_act <= 1'b0;
            vert_sync_o <= 1'b1;
        end else begin
            sync_act <= next_sync_act;
            vert_sync_o <= next_sync_act ~^ vsync_pol;
        end
    end

    // Blanking level for downstream pipelines
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vblank_o <= 1'b0;
        end else begin
            vblank_o <= in_blank;
        end
    end

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    assign irq_evt[CVT_IRQ_BLANK_BIT] = blank_start;
    assign irq_evt[CVT_IRQ_SYNC_BIT] = next_sync_act && !sync_act;
    assign irq_evt[CVT_IRQ_FRAME_BIT] = frame_start;

    // Sticky status, write one to clear; a new event wins the clear
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_stat <= CVT_REG_RST[CVT_IRQ_W-1:0];
        end else begin
            for (int i = 0; i < CVT_IRQ_W; i++) begin
                if (irq_evt[i]) begin
                    irq_stat[i] <= 1'b1;
                end else if (reg_wr_i && reg_wdata_i[i] &&
                             (reg_addr_i == CVT_IRQ_STAT_ADDR)) begin
                    irq_stat[i] <= 1'b0;
                end
            end
        end
    end

    // Mask register and level output
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_mask <= CVT_REG_RST[CVT_IRQ_W-1:0];
            irq_o <= 1'b0;
        end else begin
            if (reg_wr_i && (reg_addr_i == CVT_IRQ_MASK_ADDR)) begin
                irq_mask <= reg_wdata_i[CVT_IRQ_W-1:0];
            end
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped offsets and reserved bits read as zero
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            CVT_HGT_LO_ADDR: next_rdata = hgt_lo;
            CVT_HGT_HI_ADDR: next_rdata = {6'h00, hgt_hi};
            CVT_VND_ADDR: next_rdata = {in_blank, vnd_period};
            CVT_VSS_ADDR: next_rdata = {1'b0, vsync_start};
            CVT_VSW_ADDR: next_rdata = {vsync_pol, 4'h0, vsync_width};
            CVT_TVC_ADDR: next_rdata = {2'h0, chroma_filt_en_o,
                                        luma_filt_en_o, dac_level_sel_o,
                                        1'b0, svideo_sel_o, pal_sel_o};
            CVT_IRQ_STAT_ADDR: next_rdata = {5'h00, irq_stat};
            CVT_IRQ_MASK_ADDR: next_rdata = {5'h00, irq_mask};
            default: next_rdata = 8'h00;
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    AST_ACT_LEN: assert property (
        $rose(in_blank) |-> $past(line_idx, 2) == $past(act_height, 2))
        else $error("active phase length differs from height");

    AST_VND_STATUS: assert property (
        reg_rd_i && reg_addr_i == CVT_VND_ADDR
        |=> reg_rdata_o[CVT_VND_STAT_BIT] == $past(in_blank))
        else $error("blanking status bit wrong");

    AST_VND_LEN: assert property (
        $fell(in_blank) |-> $past(line_idx, 2) >= {3'h0, $past(vnd_period, 2)})
        else $error("non-display phase ended early");

    AST_SYNC_LEAD: assert property (
        $rose(sync_act) |-> $past(line_idx) == $past(sync_first)
        && $past(in_blank))
        else $error("sync leading edge at wrong line");

    AST_SYNC_POL: assert property (
        ##1 (vert_sync_o == (sync_act ? vsync_pol : !vsync_pol))
        || $changed(vsync_pol))
        else $error("sync polarity wrong");

    AST_SYNC_WIDTH: assert property (
        $fell(sync_act) && $past(in_blank, 2) && in_blank |->
        $past(line_idx) == $past(sync_end))
        else $error("sync width wrong");

    AST_CHROMA: assert property (
        wr_hit_tvc |=> chroma_filt_en_o == $past(reg_wdata_i[5]))
        else $error("chroma filter enable not taken");

    AST_LUMA: assert property (
        wr_hit_tvc |=> luma_filt_en_o == $past(reg_wdata_i[4]))
        else $error("luma filter enable not taken");

    AST_FORMAT: assert property (
        wr_hit_tvc |=> svideo_sel_o == $past(reg_wdata_i[1])
        && pal_sel_o == $past(reg_wdata_i[0]))
        else $error("output select not taken");

    AST_WRAP: assert property (
        frame_start |=> !in_blank ##0 line_idx == 10'h000)
        else $error("frame did not wrap");

    AST_VBLANK: assert property (
        vblank_o == $past(in_blank))
        else $error("blanking pin does not follow phase");

    AST_HGT_SPLIT: assert property (
        wr_hit_hgt_hi |=> act_height[9:8] == $past(reg_wdata_i[1:0]))
        else $error("height high bits not taken");

    AST_VND_WRITE: assert property (
        wr_hit_vnd |=> vnd_period == $past(reg_wdata_i[6:0]))
        else $error("non-display length not taken");

    AST_POL_WRITE: assert property (
        wr_hit_vsw |=> vsync_pol == $past(reg_wdata_i[CVT_VSW_POL_BIT]))
        else $error("sync polarity not taken");

    COV_FRAME: cover property (blank_start ##[1:1000] frame_start);
    COV_STATUS: cover property (reg_rd_i && reg_addr_i == CVT_VND_ADDR
        && in_blank);
    COV_TV_MODE: cover property (wr_hit_tvc ##1 pal_sel_o && svideo_sel_o);
    COV_SYNC: cover property ($rose(sync_act) ##[1:1000] $fell(sync_act));
    COV_IRQ: cover property ($rose(irq_o));

endmodule

// file: cvt_line_source.sv
/*
 * Line-rate partner: a horizontal timing source that pulses one tick
 * every TICK_GAP clocks, plus a monitor that counts lines in each phase.
 * Assumes the vertical outputs settle within two clocks of a tick.
 */
`timescale 1ns/1ps
module cvt_line_source #(
    parameter int TICK_GAP = 4
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Control and observed pins
    input wire logic run_i,
    input wire logic sync_high_i,
    input wire logic vert_sync_i,
    input wire logic vblank_i,
    // Tick and measurements
    output logic line_tick_o,
    output logic [9:0] act_lines_o,
    output logic [9:0] blank_lines_o,
    output logic [9:0] lead_lines_o,
    output logic [9:0] sync_lines_o,
    output logic [7:0] frames_o
);
    logic [7:0] gap;
    logic [9:0] n_act;
    logic [9:0] n_blank;
    logic [9:0] n_lead;
    logic [9:0] n_sync;
    logic seen_sync;
    logic was_blank;
    logic sync_on;

    // Active level follows the polarity the bench programmed
    assign sync_on = (vert_sync_i == sync_high_i);

    // ------------------------------------------------------------
    // Tick source
    // ------------------------------------------------------------
    // Wide gap so each sample sees the settled previous line
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gap <= 8'h00;
            line_tick_o <= 1'b0;
        end else begin
            gap <= (gap == 8'(TICK_GAP - 1)) ? 8'h00 : gap + 8'h01;
            line_tick_o <= run_i && (gap == 8'h00);
        end
    end

    // ------------------------------------------------------------
    // Line monitor
    // ------------------------------------------------------------
    // Blank, lead and sync counts latch at each blank-to-active wrap; active count at blank entry
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {n_act, n_blank, n_lead, n_sync} <= '0;
            {act_lines_o, blank_lines_o, lead_lines_o} <= '0;
            sync_lines_o <= '0;
            frames_o <= 8'h00;
            seen_sync <= 1'b0;
            was_blank <= 1'b0;
        end else if (line_tick_o) begin
            was_blank <= vblank_i;
            if (!vblank_i && was_blank) begin
                blank_lines_o <= n_blank;
                lead_lines_o <= n_lead;
                sync_lines_o <= n_sync;
                frames_o <= frames_o + 8'h01;
                {n_blank, n_lead, n_sync} <= '0;
                n_act <= 10'h001;
                seen_sync <= 1'b0;
            end else if (!vblank_i) begin
                n_act <= n_act + 10'h001;
            end else begin
                if (!was_blank) begin
                    act_lines_o <= n_act;
                end
                n_blank <= n_blank + 10'h001;
                if (sync_on) begin
                    n_sync <= n_sync + 10'h001;
                    seen_sync <= 1'b1;
                end else if (!seen_sync) begin
                    n_lead <= n_lead + 10'h001;
                end
            end
        end
    end
endmodule

// file: cvt_vtiming_bench.sv
/*
 * Self-checking bench for the vertical timing block: register table,
 * frame line counts through the line partner, status bit and interrupt.
 * Assumes the one-cycle strobe register port and one 100 MHz clock.
 */
`timescale 1ns/1ps
module cvt_vtiming_bench;
    import cvt_pkg::*;

    typedef struct {
        logic [7:0] a;
        logic [7:0] w;
        logic [7:0] r;
    } cvt_row_t;

    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic run = 1'b0;
    logic sync_high = 1'b0;
    logic [7:0] rdata;
    logic tick, vsync, vblank, chroma, luma, dac, svid, pal, irq;
    logic [9:0] act_n, blank_n, lead_n, sync_n;
    logic [7:0] frames;
    int n_errors = 0;
    int total_checks = 0;
    cvt_row_t rows [14] = '{
        '{8'h56, 8'hff, 8'hff}, '{8'h57, 8'hff, 8'h03},
        '{8'h58, 8'hff, 8'h7f}, '{8'h59, 8'hff, 8'h7f},
        '{8'h5a, 8'hff, 8'h87}, '{8'h5b, 8'h20, 8'h20},
        '{8'h5b, 8'h10, 8'h10}, '{8'h5b, 8'h08, 8'h08},
        '{8'h5b, 8'h02, 8'h02}, '{8'h5b, 8'h01, 8'h01},
        '{8'h5b, 8'hff, 8'h3b}, '{8'h5b, 8'h00, 8'h00},
        '{8'h60, 8'hff, 8'h00}, '{8'h5d, 8'h00, 8'h00}};
    logic [9:0] hs [2] = '{10'h100, 10'h000};
    logic [6:0] ps [2] = '{7'h09, 7'h05};
    logic [6:0] ss [2] = '{7'h02, 7'h00};
    logic [2:0] ws [2] = '{3'h1, 3'h0};
    logic pols [2] = '{1'b1, 1'b0};

    cvt_vtiming i_cvt_vtiming (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .line_tick_i(tick),
        .vert_sync_o(vsync), .vblank_o(vblank),
        .chroma_filt_en_o(chroma), .luma_filt_en_o(luma),
        .dac_level_sel_o(dac), .svideo_sel_o(svid), .pal_sel_o(pal),
        .irq_o(irq));

    cvt_line_source #(.TICK_GAP(4)) i_cvt_line_source (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .run_i(run),
        .sync_high_i(sync_high), .vert_sync_i(vsync), .vblank_i(vblank),
        .line_tick_o(tick), .act_lines_o(act_n),
        .blank_lines_o(blank_n), .lead_lines_o(lead_n),
        .sync_lines_o(sync_n), .frames_o(frames));

    // ------------------------------------------------------------
    // Clock, shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #5 clock_i = ~clock_i;
    end

    task automatic check(input string name, input logic [9:0] seen,
                         input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic wait_blank(input logic lvl);
        for (int k = 0; k < 5000 && vblank !== lvl; k++) begin
            @(posedge clock_i);
        end
    endtask

    task final_report;
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard, far beyond the few thousand cycles expected
    initial begin
        #500us;
        n_errors++;
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic [7:0] base;
        repeat (20) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        #1;
        check("reset pins", {vsync, vblank, chroma, luma, dac, svid, pal,
              irq}, 10'h080);
        for (int a = 8'h56; a <= 8'h5d; a++) begin
            rd_reg(8'(a), d);
            check("reset reg", d, 10'h000);
        end
        // Table rows: write, read back, TV pins follow control bits
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].w);
            rd_reg(rows[i].a, d);
            check("readback", d, rows[i].r);
            if (rows[i].a == 8'h5b) begin
                check("tv chroma", chroma, rows[i].w[5]);
                check("tv luma", luma, rows[i].w[4]);
                check("dac level", dac, rows[i].w[3]);
                check("s-video", svid, rows[i].w[1]);
                check("pal", pal, rows[i].w[0]);
            end
        end
        // Second set is TV use: polarity 0, width 0, format NTSC
        for (int i = 0; i < 2; i++) begin
            if (i == 1) begin
                // Restart so the new lengths count from line zero
                @(posedge clock_i);
                run <= 1'b0;
                sys_rst_i <= 1'b1;
                repeat (2) @(posedge clock_i);
                sys_rst_i <= 1'b0;
            end
            wr_reg(CVT_HGT_LO_ADDR, hs[i][7:0]);
            wr_reg(CVT_HGT_HI_ADDR, {6'h00, hs[i][9:8]});
            wr_reg(CVT_VND_ADDR, {1'b0, ps[i]});
            wr_reg(CVT_VSS_ADDR, {1'b0, ss[i]});
            wr_reg(CVT_VSW_ADDR, {pols[i], 4'h0, ws[i]});
            wr_reg(CVT_TVC_ADDR, 8'h00);
            sync_high <= pols[i];
            run <= 1'b1;
            base = frames;
            for (int k = 0; k < 20000 && frames !== base + 8'h02; k++) begin
                @(posedge clock_i);
            end
            check("frames", frames, 8'(base + 8'h02));
            check("active lines", act_n, hs[i] + 10'h001);
            check("blank lines", blank_n, 10'(ps[i]) + 10'h001);
            check("sync lead", lead_n, 10'(ss[i]) + 10'h001);
            check("sync lines", sync_n, 10'(ws[i]) + 10'h001);
            if (i == 0) begin
                wait_blank(1'b1);
                rd_reg(CVT_VND_ADDR, d);
                check("status blank", d, {2'h0, 1'b1, ps[i]});
                wait_blank(1'b0);
                rd_reg(CVT_VND_ADDR, d);
                check("status active", d, {2'h0, 1'b0, ps[i]});
            end
        end
        // Freeze the frame so no new events reach the status
        run <= 1'b0;
        repeat (8) @(posedge clock_i);
        rd_reg(CVT_IRQ_STAT_ADDR, d);
        check("irq status", d, 10'h007);
        check("irq masked", irq, 1'b0);
        wr_reg(CVT_IRQ_MASK_ADDR, 8'h01);
        repeat (2) @(posedge clock_i);
        check("irq raised", irq, 1'b1);
        wr_reg(CVT_IRQ_STAT_ADDR, 8'h01);
        repeat (2) @(posedge clock_i);
        check("irq cleared", irq, 1'b0);
        rd_reg(CVT_IRQ_STAT_ADDR, d);
        check("irq w1c", d, 10'h006);
        wr_reg(CVT_IRQ_MASK_ADDR, 8'h06);
        repeat (2) @(posedge clock_i);
        check("irq raised", irq, 1'b1);
        wr_reg(CVT_IRQ_STAT_ADDR, 8'h06);
        repeat (2) @(posedge clock_i);
        check("irq cleared", irq, 1'b0);
        rd_reg(CVT_IRQ_MASK_ADDR, d);
        check("irq mask", d, 10'h006);
        @(posedge clock_i);
        #1;
        check("rdata idle", rdata, 10'h000);
        // Reset with the line source stopped clears the stored controls
        wr_reg(CVT_TVC_ADDR, 8'h3b);
        @(posedge clock_i);
        check("tv before reset", {chroma, pal}, 10'h003);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd_reg(CVT_TVC_ADDR, d);
        check("second reset", {d[7:0], chroma, pal}, 10'h000);
        final_report();
    end
endmodule
